// file: axsm_pkg.sv
//==========================================================================
// Functional notes
// - Power-up enters start state, alive bit not yet set
// - Start moves to ready after initialisation, to fault if error word nonzero
// - Ready: power off, no error, switch-on ready
// - Ready to enabled when enable bit set
// - Enabled: power on, motion commands accepted
// - Enabled to ready when enable bit cleared
// - Nonzero control or command at start locks
// - Locked: power off; host clears control, command
// - Locked to fault once control, command zero
// - Fault: power off while error word nonzero
// - Fault to ready only when error word zero
// - Status bits alive, enabled, error, busy per state
// - Host decodes state with fixed priority
// - Fully controlled by cyclic process data only; error_in and error_event also force fault
// - Output image field order and widths fixed
// - Input image field order and widths fixed
// - Host drives reserved output fields to zero
// - Related output fields update in same cycle
// - Control byte bit 0 is enable request
// - Motion only started in enabled state
package axsm_pkg;
	// Output image widths and byte offsets
	localparam int OUT_IMG_W = 96;
	localparam int OFS_CTRL = 0;
	localparam int OFS_RSV1 = 1;
	localparam int OFS_CMD = 2;
	localparam int OFS_POS = 4;
	localparam int OFS_FORCE = 8;
	localparam int OFS_VEL = 9;
	localparam int OFS_RSV2 = 10;
	// Input image widths and byte offsets
	localparam int IN_IMG_W = 128;
	localparam int OFS_STATUS = 0;
	localparam int OFS_IRSV1 = 2;
	localparam int OFS_ERROR = 4;
	localparam int OFS_WARN = 6;
	localparam int OFS_ACTPOS = 8;
	localparam int OFS_IRSV2 = 12;
	// Control byte bit positions
	localparam int CTRL_ENABLE_BIT = 0;
	// Status word bit positions
	localparam int ST_ALIVE_BIT = 0;
	localparam int ST_ENABLED_BIT = 1;
	localparam int ST_ERROR_BIT = 2;
	localparam int ST_BUSY_BIT = 3;
	// Reset values
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [OUT_IMG_W-1:0] OUT_IMG_RST = 96'h0;
	// Default initialisation length in clock cycles
	localparam int INIT_CYCLES = 16;
	// Supervisory states
	typedef enum logic [2:0] {
		AXSM_START,
		AXSM_READY,
		AXSM_ENABLED,
		AXSM_FAULT,
		AXSM_LOCKED
	} axsm_state_t;
endpackage : axsm_pkg

// file: axsm_if.sv
`timescale 1ns/1ns
//==========================================================================
// Cyclic process-data link between host and axis
interface axsm_if;
	// Host-to-device image, valid with its strobe
	logic [axsm_pkg::OUT_IMG_W-1:0] host_to_device_image;
	logic out_strobe;
	// Device-to-host image, always valid
	logic [axsm_pkg::IN_IMG_W-1:0] device_to_host_image;
	modport device (
		input host_to_device_image,
		input out_strobe,
		output device_to_host_image
	);
	modport host (
		output host_to_device_image,
		output out_strobe,
		input device_to_host_image
	);
endinterface : axsm_if

// file: axsm_device.sv
`timescale 1ns/1ns
//==========================================================================
// Axis supervisory state machine, device end
module axsm_device #(
	parameter int INIT_LEN = axsm_pkg::INIT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic resetn,
	axsm_if.device link,
	input wire logic [15:0] error_in,
	input wire logic [15:0] warning_in,
	input wire logic [31:0] item_a,
	input wire logic error_event,
	output logic power_on,
	output logic motion_go,
	output logic [15:0] motion_cmd,
	output logic [31:0] motion_pos,
	output logic [7:0] motion_vel
);
	//======================================================================
	// Latched consistent output image
	logic [axsm_pkg::OUT_IMG_W-1:0] img_ff;
	axsm_pkg::axsm_state_t state_ff;
	axsm_pkg::axsm_state_t nxt_state;
	logic [15:0] init_cnt_ff;
	logic [15:0] status_ff;
	logic [15:0] nxt_status;
	logic power_ff;
	logic go_ff;
	logic [15:0] mcmd_ff;
	logic [31:0] mpos_ff;
	logic [7:0] mvel_ff;

	// True when a 16-bit word holds any set bit
	function automatic logic axsm_nonzero(input logic [15:0] w);
		return (w != 16'h0000);
	endfunction : axsm_nonzero

	// Field decode from latched image
	wire [7:0] host_control_byte = img_ff[axsm_pkg::OFS_CTRL*8 +: 8];
	wire [15:0] motion_command_word = img_ff[axsm_pkg::OFS_CMD*8 +: 16];
	wire [31:0] target_position = img_ff[axsm_pkg::OFS_POS*8 +: 32];
	wire [7:0] velocity_percent = img_ff[axsm_pkg::OFS_VEL*8 +: 8];
	wire enable_req = host_control_byte[axsm_pkg::CTRL_ENABLE_BIT];
	wire ctrl_clear = (host_control_byte == 8'h00)
		&& !axsm_nonzero(motion_command_word);
	wire init_done = (init_cnt_ff == 16'(INIT_LEN));
	wire err_present = axsm_nonzero(error_in);

	//======================================================================
	// Motion only in enabled state with a nonzero command
	wire nxt_go = (nxt_state == axsm_pkg::AXSM_ENABLED)
		&& axsm_nonzero(motion_command_word);
	// Power stage only in enabled state
	wire nxt_power = (nxt_state == axsm_pkg::AXSM_ENABLED);

	//======================================================================
	// Whole image captured on one strobe
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			img_ff <= axsm_pkg::OUT_IMG_RST;
		end else if (link.out_strobe) begin
			img_ff <= link.host_to_device_image;
		end
	end

	//======================================================================
	// Initialisation counter, runs in start state
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			init_cnt_ff <= 16'h0000;
		end else if (state_ff == axsm_pkg::AXSM_START && !init_done) begin
			init_cnt_ff <= init_cnt_ff + 16'h0001;
		end
	end

	//======================================================================
	// Next-state logic
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			axsm_pkg::AXSM_START: begin
				// Leave start once initialised
				if (init_done) begin
					if (!ctrl_clear) begin
						nxt_state = axsm_pkg::AXSM_LOCKED;
					end else if (err_present) begin
						nxt_state = axsm_pkg::AXSM_FAULT;
					end else begin
						nxt_state = axsm_pkg::AXSM_READY;
					end
				end
			end
			axsm_pkg::AXSM_READY: begin
				// Error first, then enable
				if (error_event || err_present) begin
					nxt_state = axsm_pkg::AXSM_FAULT;
				end else if (enable_req) begin
					nxt_state = axsm_pkg::AXSM_ENABLED;
				end
			end
			axsm_pkg::AXSM_ENABLED: begin
				// Error first, then disable
				if (error_event || err_present) begin
					nxt_state = axsm_pkg::AXSM_FAULT;
				end else if (!enable_req) begin
					nxt_state = axsm_pkg::AXSM_READY;
				end
			end
			axsm_pkg::AXSM_LOCKED: begin
				// Wait for host to clear both fields
				if (ctrl_clear) begin
					nxt_state = axsm_pkg::AXSM_FAULT;
				end
			end
			axsm_pkg::AXSM_FAULT: begin
				// Hold until the error word reads zero
				if (!err_present) begin
					nxt_state = axsm_pkg::AXSM_READY;
				end
			end
			default: begin
				// Unused codes fall back to start
				nxt_state = axsm_pkg::AXSM_START;
			end
		endcase
	end

	//======================================================================
	// Status word encoding per state
	always_comb begin
		nxt_status = axsm_pkg::STATUS_RST;
		case (nxt_state)
			// Ready: alive only
			axsm_pkg::AXSM_READY: begin
				nxt_status[axsm_pkg::ST_ALIVE_BIT] = 1'b1;
			end
			axsm_pkg::AXSM_ENABLED: begin
				nxt_status[axsm_pkg::ST_ALIVE_BIT] = 1'b1;
				nxt_status[axsm_pkg::ST_ENABLED_BIT] = 1'b1;
				// Busy follows the motion output
				nxt_status[axsm_pkg::ST_BUSY_BIT] = nxt_go;
			end
			// Fault: alive and error
			axsm_pkg::AXSM_FAULT: begin
				nxt_status[axsm_pkg::ST_ALIVE_BIT] = 1'b1;
				nxt_status[axsm_pkg::ST_ERROR_BIT] = 1'b1;
			end
			// Locked: alive, error and busy
			axsm_pkg::AXSM_LOCKED: begin
				nxt_status[axsm_pkg::ST_ALIVE_BIT] = 1'b1;
				nxt_status[axsm_pkg::ST_ERROR_BIT] = 1'b1;
				nxt_status[axsm_pkg::ST_BUSY_BIT] = 1'b1;
			end
			default: begin
				// Start reports all bits clear
				nxt_status = axsm_pkg::STATUS_RST;
			end
		endcase
	end

	//======================================================================
	// State and outputs register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_ff <= axsm_pkg::AXSM_START;
			status_ff <= axsm_pkg::STATUS_RST;
			power_ff <= 1'b0;
			go_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			status_ff <= nxt_status;
			power_ff <= nxt_power;
			go_ff <= nxt_go;
		end
	end

	//======================================================================
	// Motion set taken together from one image
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mcmd_ff <= 16'h0000;
			mpos_ff <= 32'h0000_0000;
			mvel_ff <= 8'h00;
		end else if (nxt_go) begin
			mcmd_ff <= motion_command_word;
			mpos_ff <= target_position;
			mvel_ff <= velocity_percent;
		end else begin
			// Idle command while not moving
			mcmd_ff <= 16'h0000;
		end
	end

	//======================================================================
	// Input image assembly
	assign link.device_to_host_image = {
		32'h0000_0000,
		item_a,
		warning_in,
		error_in,
		16'h0000,
		status_ff
	};
	// Outputs come straight from flip-flops
	assign power_on = power_ff;
	assign motion_go = go_ff;
	assign motion_cmd = mcmd_ff;
	assign motion_pos = mpos_ff;
	assign motion_vel = mvel_ff;
endmodule : axsm_device

// file: axsm_host.sv
`timescale 1ns/1ns
//==========================================================================
// Host end: builds the output image and decodes the state
module axsm_host (
	input wire logic clk_sys,
	input wire logic resetn,
	axsm_if.host link,
	input wire logic apply,
	input wire logic enable,
	input wire logic [15:0] cmd,
	input wire logic [31:0] pos,
	input wire logic [7:0] vel,
	output axsm_pkg::axsm_state_t dev_state,
	output logic [15:0] dev_error,
	output logic [15:0] dev_warning,
	output logic [31:0] dev_pos
);
	//======================================================================
	// Image and strobe registers
	logic [axsm_pkg::OUT_IMG_W-1:0] img_ff;
	logic strobe_ff;
	axsm_pkg::axsm_state_t state_ff;
	axsm_pkg::axsm_state_t nxt_state;
	logic [15:0] err_ff;
	logic [15:0] warn_ff;
	logic [31:0] pos_ff;
	wire [15:0] st = link.device_to_host_image[axsm_pkg::OFS_STATUS*8 +: 16];

	// Reserved fields and force byte zero
	wire [axsm_pkg::OUT_IMG_W-1:0] nxt_img = {
		16'h0000, vel, 8'h00, pos, cmd, 8'h00, 7'h00, enable
	};

	//======================================================================
	// All fields sent in one strobe
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			img_ff <= axsm_pkg::OUT_IMG_RST;
			strobe_ff <= 1'b0;
		end else begin
			strobe_ff <= apply;
			if (apply) begin
				img_ff <= nxt_img;
			end
		end
	end

	//======================================================================
	// State decode by priority
	always_comb begin
		if (!st[axsm_pkg::ST_ALIVE_BIT]) begin
			nxt_state = axsm_pkg::AXSM_START;
		end else if (st[axsm_pkg::ST_ENABLED_BIT]) begin
			nxt_state = axsm_pkg::AXSM_ENABLED;
		end else if (st[axsm_pkg::ST_ERROR_BIT] && st[axsm_pkg::ST_BUSY_BIT]) begin
			nxt_state = axsm_pkg::AXSM_LOCKED;
		end else if (st[axsm_pkg::ST_ERROR_BIT]) begin
			nxt_state = axsm_pkg::AXSM_FAULT;
		end else begin
			nxt_state = axsm_pkg::AXSM_READY;
		end
	end

	//======================================================================
	// Register decoded input image
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_ff <= axsm_pkg::AXSM_START;
			err_ff <= 16'h0000;
			warn_ff <= 16'h0000;
			pos_ff <= 32'h0000_0000;
		end else begin
			state_ff <= nxt_state;
			err_ff <= link.device_to_host_image[axsm_pkg::OFS_ERROR*8 +: 16];
			warn_ff <= link.device_to_host_image[axsm_pkg::OFS_WARN*8 +: 16];
			pos_ff <= link.device_to_host_image[axsm_pkg::OFS_ACTPOS*8 +: 32];
		end
	end

	assign link.host_to_device_image = img_ff;
	assign link.out_strobe = strobe_ff;
	assign dev_state = state_ff;
	assign dev_error = err_ff;
	assign dev_warning = warn_ff;
	assign dev_pos = pos_ff;
endmodule : axsm_host

// file: axsm_assertions.sv
`timescale 1ns/1ns
//==========================================================================
// Link watcher: state codes and transitions seen on the images
module axsm_assertions #(
	parameter int INIT_LEN = axsm_pkg::INIT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [axsm_pkg::OUT_IMG_W-1:0] host_to_device_image,
	input wire logic out_strobe,
	input wire logic [axsm_pkg::IN_IMG_W-1:0] device_to_host_image
);
	// Field views of both images
	wire logic [3:0] st4 = device_to_host_image[3:0];
	wire logic [15:0] err = device_to_host_image[47:32];
	wire logic [7:0] ctrl = host_to_device_image[7:0];
	wire logic [15:0] cmd = host_to_device_image[31:16];
	logic [7:0] start_cnt_ff; // Cycles spent in start
	//======================================================================
	// Count the time spent in start, saturating
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			start_cnt_ff <= 8'h00;
		end else if (!st4[0] && start_cnt_ff != 8'hff) begin
			start_cnt_ff <= start_cnt_ff + 8'h01;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Requests and states used by the transitions
	sequence s_en_req; out_strobe && ctrl[0]; endsequence
	sequence s_dis_req; out_strobe && !ctrl[0]; endsequence
	sequence s_ready_ok; st4 == 4'h1 && err == 16'h0000; endsequence
	init_time_a: assert property (start_cnt_ff <= INIT_LEN + 4)
		else $error("start state held too long");
	status_code_a: assert property (
		st4 inside {4'h0, 4'h1, 4'h3, 4'hb, 4'h5, 4'hd})
		else $error("illegal status code");
	rsv_input_a: assert property (
		device_to_host_image[31:16] == 16'h0000
		&& device_to_host_image[127:96] == 32'h0000_0000)
		else $error("reserved input field not zero");
	enable_a: assert property (
		s_ready_ok ##0 s_en_req |-> ##[1:3] st4[2:0] == 3'h3)
		else $error("enable did not reach enabled");
	disable_a: assert property (
		(st4[1] && err == 16'h0000) ##0 s_dis_req |-> ##[1:3] st4 == 4'h1)
		else $error("disable did not reach ready");
	unlock_a: assert property (
		st4 == 4'hd && ctrl == 8'h00 && cmd == 16'h0000
		|-> ##[1:3] st4 == 4'h5) else $error("locked did not pass to fault");
	fault_exit_a: assert property (
		st4 == 4'h5 && err == 16'h0000 |-> ##1 st4 == 4'h1)
		else $error("fault did not clear");
	err_fault_a: assert property (
		(st4 == 4'h1 || st4[1]) && err != 16'h0000
		|-> ##[1:3] st4 == 4'h5) else $error("error did not enter fault");
endmodule : axsm_assertions

// file: tb.sv
`timescale 1ns/1ns
//==========================================================================
// Bench: host and device ends joined by the link
module tb;
	logic clk_sys; // System clock
	logic resetn; // Active-low reset
	logic apply, enable, error_event; // Host and device strobes
	logic [15:0] cmd, error_in, warning_in;
	logic [31:0] pos, item_a;
	logic [7:0] vel;
	logic power_on, motion_go; // Device outputs
	logic [15:0] motion_cmd, dev_error, dev_warning;
	logic [31:0] motion_pos, dev_pos;
	logic [7:0] motion_vel;
	axsm_pkg::axsm_state_t dev_state; // Host view of state
	int n_errors = 0;
	int checks = 0;
	axsm_if link_if();
	axsm_device #(.INIT_LEN(8)) axsm_device_inst (.clk_sys(clk_sys),
		.resetn(resetn), .link(link_if.device), .error_in(error_in),
		.warning_in(warning_in), .item_a(item_a), .error_event(error_event),
		.power_on(power_on), .motion_go(motion_go), .motion_cmd(motion_cmd),
		.motion_pos(motion_pos), .motion_vel(motion_vel));
	axsm_host axsm_host_inst (.clk_sys(clk_sys), .resetn(resetn),
		.link(link_if.host), .apply(apply), .enable(enable), .cmd(cmd),
		.pos(pos), .vel(vel), .dev_state(dev_state), .dev_error(dev_error),
		.dev_warning(dev_warning), .dev_pos(dev_pos));
	axsm_assertions #(.INIT_LEN(8)) axsm_assertions_inst (.clk_sys(clk_sys),
		.resetn(resetn), .out_strobe(link_if.out_strobe),
		.host_to_device_image(link_if.host_to_device_image),
		.device_to_host_image(link_if.device_to_host_image));
	//======================================================================
	// Clock and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		#40000;
		n_errors++;
		test_done();
	end
	//======================================================================
	// Shared tasks
	task automatic test_done;
		if (n_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask : tick
	// One host update: all fields on one apply pulse
	task automatic send(input logic en, input logic [15:0] c,
		input logic [31:0] p, input logic [7:0] v);
		tick(1);
		apply = 1'b1;
		enable = en;
		cmd = c;
		pos = p;
		vel = v;
		tick(1);
		apply = 1'b0;
	endtask : send
	// Bounded wait for the host's decoded state
	task automatic want(input axsm_pkg::axsm_state_t s);
		for (int i = 0; i < 20 && dev_state !== s; i++) tick(1);
		chk(32'(dev_state), 32'(s));
	endtask : want
	task automatic do_reset;
		resetn = 1'b0;
		tick(6);
		resetn = 1'b1;
	endtask : do_reset
	//======================================================================
	// Scenarios
	task automatic t_start;
		do_reset();
		chk(32'(dev_state), 32'(axsm_pkg::AXSM_START));
		chk(32'(link_if.device_to_host_image[15:0]), 32'h0);
		want(axsm_pkg::AXSM_READY);
		chk(32'(link_if.device_to_host_image[15:0]), 32'h1);
		chk(32'(power_on), 32'h0);
	endtask : t_start
	task automatic t_enable;
		send(1'b1, 16'h0000, 32'h0, 8'h00);
		want(axsm_pkg::AXSM_ENABLED);
		chk(32'(power_on), 32'h1);
		send(1'b1, 16'h0104, 32'h0000_03e8, 8'h32);
		tick(4);
		chk(32'(motion_go), 32'h1);
		chk(32'({motion_cmd, motion_vel}), 32'h0001_0432);
		chk(motion_pos, 32'h0000_03e8);
		chk(32'(link_if.host_to_device_image === {16'h0000, 8'h32, 8'h00,
			32'h0000_03e8, 16'h0104, 8'h00, 8'h01}), 32'h1);
		chk(32'(link_if.device_to_host_image[95:48] === {item_a,
			warning_in}), 32'h1);
		chk(dev_pos, item_a);
		chk(32'(dev_warning), 32'h0000_00a5);
	endtask : t_enable
	task automatic t_disable;
		send(1'b0, 16'h0000, 32'h0, 8'h00);
		want(axsm_pkg::AXSM_READY);
		chk(32'(power_on), 32'h0);
		send(1'b0, 16'h0001, 32'h0, 8'h10);
		tick(4);
		chk(32'(motion_go), 32'h0);
	endtask : t_disable
	task automatic t_fault;
		send(1'b1, 16'h0000, 32'h0, 8'h00);
		want(axsm_pkg::AXSM_ENABLED);
		error_in = 16'h0011;
		error_event = 1'b1;
		tick(1);
		error_event = 1'b0;
		want(axsm_pkg::AXSM_FAULT);
		chk(32'(power_on), 32'h0);
		chk(32'(dev_error), 32'h0011);
		send(1'b0, 16'h0000, 32'h0, 8'h00);
		tick(4);
		chk(32'(dev_state), 32'(axsm_pkg::AXSM_FAULT));
		error_in = 16'h0000;
		want(axsm_pkg::AXSM_READY);
	endtask : t_fault
	task automatic t_lock;
		do_reset();
		send(1'b1, 16'h0001, 32'h0, 8'h00);
		want(axsm_pkg::AXSM_LOCKED);
		chk(32'(power_on), 32'h0);
		chk(32'(link_if.device_to_host_image[3:0]), 32'hd);
		send(1'b0, 16'h0000, 32'h0, 8'h00);
		want(axsm_pkg::AXSM_FAULT);
		want(axsm_pkg::AXSM_READY);
		// Error word set at start leads to fault, not ready
		error_in = 16'h0003;
		do_reset();
		want(axsm_pkg::AXSM_FAULT);
		chk(32'(power_on), 32'h0);
		error_in = 16'h0000;
		want(axsm_pkg::AXSM_READY);
	endtask : t_lock
	//======================================================================
	// Main sequence
	initial begin
		resetn = 1'b0;
		apply = 1'b0;
		enable = 1'b0;
		cmd = 16'h0000;
		pos = 32'h0000_0000;
		vel = 8'h00;
		error_in = 16'h0000;
		warning_in = 16'h00a5;
		item_a = 32'h1234_5678;
		error_event = 1'b0;
		t_start();
		t_enable();
		t_disable();
		t_fault();
		t_lock();
		test_done();
	end
endmodule : tb
